// ==== hdl/fault_pkg.sv ====
package fault_pkg;

  // ************************************************************
  // fault register geometry
  // ************************************************************
  localparam int NREG = 25;
  localparam int FW = 8;
  localparam int AW = 12;

  // status register indices
  localparam logic [4:0] IDX_PIN_INPUT = 5'h00;
  localparam logic [4:0] IDX_UNDERVOLTAGE = 5'h01;
  localparam logic [4:0] IDX_OVERVOLTAGE = 5'h02;
  localparam logic [4:0] IDX_UNDERTEMP = 5'h03;
  localparam logic [4:0] IDX_OVERTEMP = 5'h04;
  localparam logic [4:0] IDX_TONE_IF = 5'h05;
  localparam logic [4:0] IDX_HOST_PROTO = 5'h06;
  localparam logic [4:0] IDX_HOST_CMD_RX = 5'h07;
  localparam logic [4:0] IDX_HOST_RESP_RX = 5'h08;
  localparam logic [4:0] IDX_NVM = 5'h12;
  localparam logic [4:0] IDX_SUPPLY = 5'h13;
  localparam logic [4:0] IDX_VOLT_SELFTEST = 5'h17;
  localparam logic [4:0] IDX_TEMP_SELFTEST = 5'h18;

  // summary group membership, one bit per status register
  localparam logic [NREG-1:0] GRP_NVM = 25'h0040000;
  localparam logic [NREG-1:0] GRP_SYSTEM = 25'h0780000;
  localparam logic [NREG-1:0] GRP_LINK = 25'h003ffe0;
  localparam logic [NREG-1:0] GRP_TEMP = 25'h1000018;
  localparam logic [NREG-1:0] GRP_CELL = 25'h0800006;
  localparam logic [NREG-1:0] GRP_PIN = 25'h0000001;

  // summary bit positions
  localparam int SUM_NVM = 0;
  localparam int SUM_SYSTEM = 1;
  localparam int SUM_LINK = 2;
  localparam int SUM_TEMP = 3;
  localparam int SUM_CELL = 4;
  localparam int SUM_PIN = 5;
  localparam int SUM_W = 6;

  // ************************************************************
  // address map
  // ************************************************************
  localparam logic [AW-1:0] STAT_BASE = 12'h000;
  localparam logic [AW-1:0] RST_BASE = 12'h080;
  localparam logic [AW-1:0] MSK_BASE = 12'h100;
  localparam logic [AW-1:0] SUMMARY_ADDR = 12'h180;
  localparam logic [AW-1:0] CTRL_ADDR = 12'h184;

  // control register fields
  localparam int CTRL_ALERT_EN = 0;
  localparam int CTRL_TONE_EN = 1;
  localparam int CTRL_HB_EN = 2;
  localparam int CTRL_PIN_LEVEL = 3;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [FW-1:0] MASK_RESET = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_KHZ = 40000;
  localparam int TONE_RETRY_US = 100;
  localparam int HB_PERIOD_US = 50;
  localparam int TONE_RETRY_CYC = TONE_RETRY_US * CLK_KHZ / 1000;
  localparam int HB_PERIOD_CYC = HB_PERIOD_US * CLK_KHZ / 1000;
  localparam int TW = 16;

  // ************************************************************
  // modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_SHUTDOWN = 2'b10
  } pwr_mode_t;

  typedef enum logic [1:0] {
    TONE_OFF = 2'b00,
    TONE_HEARTBEAT = 2'b01,
    TONE_FAULT = 2'b10
  } tone_state_t;

endpackage

// ==== hdl/fault_input_sync.sv ====
`timescale 1ns/1ps
module fault_input_sync
  import fault_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // levels
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage_reg;
  logic [W-1:0] sync_reg;

  // two flops; the first is read by the second only
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      stage_reg <= asyncIn;
      sync_reg <= stage_reg;
    end
  end

  assign syncOut = sync_reg;

endmodule

// ==== hdl/tone_period_timer.sv ====
`timescale 1ns/1ps
module tone_period_timer
  import fault_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic restart,
  input wire logic [TW-1:0] period,
  output logic tick
);

  logic [TW-1:0] count_reg;
  logic [TW-1:0] count_next;

  // wraps at period-1; restart lines it up with a state change
  assign tick = (count_reg == period - 16'h0001);
  assign count_next = (restart || tick) ? '0 : count_reg + 16'h0001;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule

// ==== hdl/fault_aggregation_signaling.sv ====
// Functional notes
// - status, reset and mask bit per fault
// - unmasked fault drives alert or fault tone
// - monitor faults in active and sleep
// - no fault monitoring during shutdown
// - summary shows only unmasked faults
// - nvm group ORs unmasked nvm bits
// - system group ORs supply and internal bits
// - link group ORs tone and port bits
// - temperature group ORs temperature fault bits
// - cell voltage group ORs voltage fault bits
// - pin group ORs pin input fault bits
// - host response rx status needs multidrop
// - status latches until reset bit clears
// - last clear releases alert, resumes heartbeat
// - reset ignored while condition still present
// - reset and mask registers mirror status
// - masked faults update status, not signalled
// - masking active fault releases the alert
// - only unmasked faults stop cell balancing
// - gather detector inputs into status registers
// - alert drives low only when enabled
// - stack repeats fault tone, stops heartbeat
`timescale 1ns/1ps
module fault_aggregation_signaling
  import fault_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic [AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fault detectors, asynchronous levels
  input wire logic [NREG*FW-1:0] faultIn,
  // device configuration from core logic
  input wire logic [1:0] pwrMode,
  input wire logic baseDevice,
  input wire logic multidrop,
  // open-drain alert pin
  input wire logic alertOutNIn,
  output logic alertOutN,
  output logic alertOutNOeN,
  // stack fault tone interface
  output logic faultTone,
  output logic heartbeatTone,
  // balancing and summary
  output logic balanceStop,
  output logic [SUM_W-1:0] faultSummary
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [NREG*FW-1:0] faultSync;
  logic alertPinLow;

  fault_input_sync #(.W(NREG*FW)) u_fault_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(faultIn),
    .syncOut(faultSync)
  );

  // the pin idles high; syncing its inverse makes the reset value match idle
  fault_input_sync #(.W(1)) u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .asyncIn(~alertOutNIn),
    .syncOut(alertPinLow)
  );

  // ************************************************************
  // apb decode
  // ************************************************************
  logic [4:0] wordIdx;
  logic inLow;
  logic idxOk;
  logic hitStat;
  logic hitRst;
  logic hitMsk;
  logic hitSum;
  logic hitCtrl;
  logic setupPh;
  logic wrEn;
  logic slvErr;
  logic monitorOn;
  logic respInvalid;

  // status, reset and mask banks share the word index
  assign wordIdx = paddr[6:2];
  assign inLow = (paddr[AW-1:9] == 3'h0) && (paddr[1:0] == 2'h0);
  assign idxOk = (wordIdx < 5'(NREG));
  assign hitStat = inLow && idxOk && (paddr[8:7] == STAT_BASE[8:7]);
  assign hitRst = inLow && idxOk && (paddr[8:7] == RST_BASE[8:7]);
  assign hitMsk = inLow && idxOk && (paddr[8:7] == MSK_BASE[8:7]);
  assign hitSum = (paddr == SUMMARY_ADDR);
  assign hitCtrl = (paddr == CTRL_ADDR);
  assign slvErr = !(hitStat || hitRst || hitMsk || hitSum || hitCtrl);
  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign pready = 1'b1;

  // monitoring stops only in shutdown
  assign monitorOn = (pwr_mode_t'(pwrMode) != PWR_SHUTDOWN);
  assign respInvalid = !multidrop;

  // ************************************************************
  // fault register banks
  // ************************************************************
  logic [FW-1:0] statusReg [NREG];
  logic [FW-1:0] maskReg [NREG];
  logic [NREG-1:0] regAny;
  logic [NREG*FW-1:0] clrFlat;
  logic [NREG*FW-1:0] statusFlat;
  logic [NREG*FW-1:0] maskFlat;

  for (genvar i = 0; i < NREG; i++)
  begin : g_fault
    logic [FW-1:0] src;
    logic [FW-1:0] strobe;
    logic [FW-1:0] clear;
    logic [FW-1:0] status_next;
    logic [FW-1:0] mask_next;
    logic [FW-1:0] live;
    logic hitThis;

    assign src = faultSync[i*FW +: FW];
    assign hitThis = (wordIdx == 5'(i));
    // a reset write is a one-cycle strobe, never stored
    assign strobe = (wrEn && hitRst && hitThis) ? pwdata[FW-1:0] : '0;
    // a bit whose condition is still present refuses the clear
    assign clear = strobe & ~src;
    // a new event wins over a clear in the same cycle
    assign status_next = (statusReg[i] & ~clear) | (src & {FW{monitorOn}});
    assign mask_next = (wrEn && hitMsk && hitThis) ? pwdata[FW-1:0] : maskReg[i];
    // masked bits keep updating status but leave signalling
    assign live = (respInvalid && (i == IDX_HOST_RESP_RX)) ? '0 : statusReg[i] & ~maskReg[i];
    assign regAny[i] = |live;
    assign clrFlat[i*FW +: FW] = clear;
    assign statusFlat[i*FW +: FW] = statusReg[i];
    assign maskFlat[i*FW +: FW] = maskReg[i];

    // two stored bits per source: status and mask; the reset strobe is not stored
    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        statusReg[i] <= '0;
        maskReg[i] <= MASK_RESET;
      end
      else
      begin
        statusReg[i] <= status_next;
        maskReg[i] <= mask_next;
      end
    end
  end

  // ************************************************************
  // summary groups
  // ************************************************************
  logic [SUM_W-1:0] summary;
  logic anyUnmasked;

  // each group ORs only the unmasked bits of its registers
  assign summary[SUM_NVM] = |(regAny & GRP_NVM);
  assign summary[SUM_SYSTEM] = |(regAny & GRP_SYSTEM);
  assign summary[SUM_LINK] = |(regAny & GRP_LINK);
  assign summary[SUM_TEMP] = |(regAny & GRP_TEMP);
  assign summary[SUM_CELL] = |(regAny & GRP_CELL);
  assign summary[SUM_PIN] = |(regAny & GRP_PIN);
  assign anyUnmasked = |summary;

  // ************************************************************
  // control register and read path
  // ************************************************************
  logic [CTRL_W-1:0] ctrlReg;
  logic [CTRL_W-1:0] ctrlNext;
  logic [FW-1:0] statRead;
  logic [31:0] rdData;
  logic [31:0] prdataReg;
  logic pslverrReg;

  assign ctrlNext = (wrEn && hitCtrl) ? pwdata[CTRL_W-1:0] : ctrlReg;
  // invalid host response status reads as zero outside multidrop
  assign statRead = (respInvalid && wordIdx == IDX_HOST_RESP_RX) ? '0 : statusReg[wordIdx];
  // reset bank always reads zero
  assign rdData = hitStat ? {24'h0, statRead} :
                  hitMsk ? {24'h0, maskReg[wordIdx]} :
                  hitSum ? {26'h0, summary} :
                  hitCtrl ? {28'h0, ~alertPinLow, ctrlReg} : 32'h0;

  // read data is caught in setup so access completes with no wait
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrlReg <= CTRL_RESET;
      prdataReg <= '0;
      pslverrReg <= 1'b0;
    end
    else
    begin
      ctrlReg <= ctrlNext;
      prdataReg <= setupPh ? (pwrite ? 32'h0 : rdData) : prdataReg;
      pslverrReg <= setupPh ? slvErr : pslverrReg;
    end
  end

  assign prdata = prdataReg;
  assign pslverr = pslverrReg;

  // ************************************************************
  // alert pin and balancing
  // ************************************************************
  logic alertOeNReg;
  logic balanceReg;
  logic alertDrive;

  // open drain: only ever pulls low, and only when enabled
  assign alertDrive = baseDevice && ctrlReg[CTRL_ALERT_EN] && anyUnmasked;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alertOeNReg <= 1'b1;
      balanceReg <= 1'b0;
    end
    else
    begin
      alertOeNReg <= !alertDrive;
      balanceReg <= anyUnmasked;
    end
  end

  assign alertOutN = 1'b0;
  assign alertOutNOeN = alertOeNReg;
  assign balanceStop = balanceReg;
  assign faultSummary = summary;

  // ************************************************************
  // stack tone sequencer
  // ************************************************************
  tone_state_t toneReg;
  tone_state_t toneNext;
  logic toneRestart;
  logic toneTick;
  logic [TW-1:0] tonePeriod;
  logic faultToneReg;
  logic hbToneReg;

  // fault tone beats heartbeat; heartbeat resumes once cleared or masked
  always_comb
  begin
    if (baseDevice || !monitorOn)
      toneNext = TONE_OFF;
    else if (anyUnmasked && ctrlReg[CTRL_TONE_EN])
      toneNext = TONE_FAULT;
    else if (ctrlReg[CTRL_HB_EN])
      toneNext = TONE_HEARTBEAT;
    else
      toneNext = TONE_OFF;
  end

  assign toneRestart = (toneNext != toneReg);
  assign tonePeriod = (toneReg == TONE_FAULT) ? TW'(TONE_RETRY_CYC) : TW'(HB_PERIOD_CYC);

  tone_period_timer u_tone_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .restart(toneRestart),
    .period(tonePeriod),
    .tick(toneTick)
  );

  // first tone on entry, then one per period
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      toneReg <= TONE_OFF;
      faultToneReg <= 1'b0;
      hbToneReg <= 1'b0;
    end
    else
    begin
      toneReg <= toneNext;
      faultToneReg <= (toneNext == TONE_FAULT) && (toneRestart || toneTick);
      hbToneReg <= (toneNext == TONE_HEARTBEAT) && (toneRestart || toneTick);
    end
  end

  assign faultTone = faultToneReg;
  assign heartbeatTone = hbToneReg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_clear_needs_strobe: assert property (
    ((($past(statusFlat) & ~statusFlat) & ~$past(clrFlat)) == '0))
    else $error("status bit fell without an accepted reset");

  a_clear_blocked_live: assert property (
    (wrEn && hitRst && (wordIdx == IDX_OVERVOLTAGE) && (pwdata[FW-1:0] != 8'h00))
    |=> (($past(faultSync[IDX_OVERVOLTAGE*FW +: FW]) & ~statusReg[IDX_OVERVOLTAGE]
         & $past(pwdata[FW-1:0])) == '0))
    else $error("reset cleared a bit whose condition was present");

  a_shutdown_no_set: assert property (
    !monitorOn |=> ((statusFlat & ~$past(statusFlat)) == '0))
    else $error("status set while in shutdown");

  a_summary_masked: assert property (
    ((statusFlat & ~maskFlat) == '0) |-> (summary == '0))
    else $error("masked register reached summary");

  a_alert_on_fault: assert property (
    (baseDevice && ctrlReg[CTRL_ALERT_EN] && anyUnmasked) ##1 $stable(baseDevice)
    |-> !alertOutNOeN)
    else $error("alert not driven for unmasked fault");

  a_alert_release: assert property (
    (baseDevice && $fell(anyUnmasked)) |=> alertOutNOeN)
    else $error("alert held after last unmasked fault left");

  a_alert_disabled: assert property (
    !ctrlReg[CTRL_ALERT_EN] |=> alertOutNOeN)
    else $error("alert driven while output disabled");

  a_fault_stops_hb: assert property (
    (toneReg == TONE_FAULT) |-> !heartbeatTone)
    else $error("heartbeat sent during fault tone");

  a_fault_tone_entry: assert property (
    $rose(toneReg == TONE_FAULT) |-> faultTone)
    else $error("fault tone missing on fault entry");

  a_reset_reads_zero: assert property (
    (setupPh && !pwrite && hitRst) |=> (prdata == 32'h0))
    else $error("reset register read nonzero");

  a_resp_invalid: assert property (
    (setupPh && !pwrite && hitStat && wordIdx == IDX_HOST_RESP_RX && !multidrop)
    |=> (prdata == 32'h0))
    else $error("host response status visible outside multidrop");

  a_balance_masked: assert property (
    (!anyUnmasked ##1 !anyUnmasked) |-> !balanceStop)
    else $error("balancing stopped without unmasked fault");

  c_fault_tone: cover property (faultTone);
  c_heartbeat: cover property (heartbeatTone ##1 !heartbeatTone);
  c_alert_low: cover property (!alertOutNOeN);
  c_cleared: cover property ($fell(anyUnmasked));

endmodule

// ==== dv/alert_host_model.sv ====
`timescale 1ns/1ps
module alert_host_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // open-drain alert pin
  input wire logic alertOutN,
  input wire logic alertOutNOeN,
  output logic pinLevel,
  output logic [7:0] alertCount
);
  // ********
  // pin side
  // ********
  logic pinLast;
  // board pull-up wins whenever the device releases the pin
  assign pinLevel = alertOutNOeN ? 1'b1 : alertOutN;
  // host counts each falling edge as one alert
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinLast <= 1'b1;
      alertCount <= 8'h00;
    end
    else
    begin
      pinLast <= pinLevel;
      if (pinLast && !pinLevel)
        alertCount <= alertCount + 8'h01;
    end
  end
endmodule

// ==== dv/fault_aggregation_signaling_bench.sv ====
`timescale 1ns/1ps
module fault_aggregation_signaling_bench
  import fault_pkg::*;
;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NREG*FW-1:0] faultIn;
  logic [1:0] pwrMode;
  logic baseDevice, multidrop, pinLevel, alertOutN, alertOutNOeN;
  logic faultTone, heartbeatTone, balanceStop;
  logic [SUM_W-1:0] faultSummary;
  logic [7:0] alertCount;
  int nMismatch, compares;

  fault_aggregation_signaling dut (
    .core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .faultIn(faultIn), .pwrMode(pwrMode), .baseDevice(baseDevice),
    .multidrop(multidrop), .alertOutNIn(pinLevel), .alertOutN(alertOutN),
    .alertOutNOeN(alertOutNOeN), .faultTone(faultTone), .heartbeatTone(heartbeatTone),
    .balanceStop(balanceStop), .faultSummary(faultSummary));
  alert_host_model host (
    .core_clk(core_clk), .nrst(nrst), .alertOutN(alertOutN),
    .alertOutNOeN(alertOutNOeN), .pinLevel(pinLevel), .alertCount(alertCount));

  // *******
  // helpers
  // *******
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, nMismatch);
    if (nMismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      chk(0, 1, "apb wait");
      conclude();
    end
  endtask
  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask
  function automatic logic [AW-1:0] adr(input logic [AW-1:0] base, input int i);
    return base + AW'(4 * i);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // a fault level needs two sync stages and a latch edge before it shows
  task automatic setF(input int b, input logic v);
    @(posedge core_clk);
    faultIn[b] <= v;
    tick(5);
  endtask
  task automatic waitTone(input logic flt, input int lim);
    int n;
    n = 0;
    while (((flt ? faultTone : heartbeatTone) !== 1'b1) && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(n < lim, 1, "tone pulse");
  endtask
  // index to summary bit, by group membership
  function automatic int grp(input int i);
    if (i == 0)
      return SUM_PIN;
    if (i < 3 || i == 23)
      return SUM_CELL;
    if (i < 5 || i == 24)
      return SUM_TEMP;
    if (i < 18)
      return SUM_LINK;
    return (i == 18) ? SUM_NVM : SUM_SYSTEM;
  endfunction

  // *********
  // scenarios
  // *********
  task automatic testReset();
    rchk(CTRL_ADDR, 32'h8, "ctrl reset, idle pin high");
    rchk(adr(MSK_BASE, 5), MASK_RESET, "mask reset");
    rchk(adr(STAT_BASE, 24), 32'h0, "status reset");
    apb(1'b1, adr(MSK_BASE, 24), 32'h5a);
    rchk(adr(MSK_BASE, 24), 32'h5a, "mask readback");
    apb(1'b1, adr(MSK_BASE, 24), 32'h0);
    apb(1'b1, adr(RST_BASE, 3), 32'hff);
    rchk(adr(RST_BASE, 3), 32'h0, "strobe reads zero");
    apb(1'b0, 12'h1fc, 32'h0);
    chk(er, 1, "unmapped error");
    $display("test reset done");
  endtask
  task automatic testLatch();
    setF(16, 1'b1);
    rchk(adr(STAT_BASE, IDX_OVERVOLTAGE), 32'h1, "ov latched");
    chk(faultSummary, 32'h10, "cell summary");
    chk(alertOutNOeN, 1, "alert disabled");
    apb(1'b1, CTRL_ADDR, 32'h1);
    tick(2);
    chk(alertOutNOeN, 0, "alert driven");
    chk(alertCount, 1, "host saw alert");
    apb(1'b1, adr(RST_BASE, IDX_OVERVOLTAGE), 32'h1);
    rchk(adr(STAT_BASE, IDX_OVERVOLTAGE), 32'h1, "clear refused");
    setF(16, 1'b0);
    rchk(adr(STAT_BASE, IDX_OVERVOLTAGE), 32'h1, "still latched");
    apb(1'b1, adr(RST_BASE, IDX_OVERVOLTAGE), 32'h1);
    tick(2);
    chk(alertOutNOeN, 1, "alert released");
    rchk(adr(STAT_BASE, IDX_OVERVOLTAGE), 32'h0, "ov cleared");
    $display("test latch done");
  endtask
  task automatic testMask();
    setF(26, 1'b1);
    chk(balanceStop, 1, "balance stop");
    apb(1'b1, adr(MSK_BASE, IDX_UNDERTEMP), 32'h4);
    tick(2);
    chk(faultSummary, 32'h0, "masked summary");
    chk(alertOutNOeN, 1, "mask releases alert");
    chk(balanceStop, 0, "masked keeps balance");
    rchk(adr(STAT_BASE, IDX_UNDERTEMP), 32'h4, "masked status kept");
    setF(26, 1'b0);
    apb(1'b1, adr(RST_BASE, IDX_UNDERTEMP), 32'h4);
    apb(1'b1, adr(MSK_BASE, IDX_UNDERTEMP), 32'h0);
    rchk(adr(STAT_BASE, IDX_UNDERTEMP), 32'h0, "ut cleared");
    $display("test mask done");
  endtask
  task automatic testGroups();
    @(posedge core_clk);
    multidrop <= 1'b1;
    for (int i = 0; i < NREG; i++)
    begin
      setF(i * FW + 7, 1'b1);
      chk(faultSummary, 32'h1 << grp(i), "group bit");
      setF(i * FW + 7, 1'b0);
      apb(1'b1, adr(RST_BASE, i), 32'h80);
      tick(1);
      chk(faultSummary, 32'h0, "group cleared");
    end
    @(posedge core_clk);
    multidrop <= 1'b0;
    setF(IDX_HOST_RESP_RX * FW, 1'b1);
    rchk(adr(STAT_BASE, IDX_HOST_RESP_RX), 32'h0, "resp rx invalid");
    chk(faultSummary, 32'h0, "resp rx no summary");
    setF(IDX_HOST_RESP_RX * FW, 1'b0);
    apb(1'b1, adr(RST_BASE, IDX_HOST_RESP_RX), 32'h1);
    $display("test groups done");
  endtask
  task automatic testModes();
    @(posedge core_clk);
    pwrMode <= PWR_SHUTDOWN;
    setF(8, 1'b1);
    rchk(adr(STAT_BASE, IDX_UNDERVOLTAGE), 32'h0, "shutdown ignores");
    @(posedge core_clk);
    pwrMode <= PWR_SLEEP;
    tick(5);
    rchk(adr(STAT_BASE, IDX_UNDERVOLTAGE), 32'h1, "sleep monitors");
    setF(8, 1'b0);
    apb(1'b1, adr(RST_BASE, IDX_UNDERVOLTAGE), 32'h1);
    @(posedge core_clk);
    pwrMode <= PWR_ACTIVE;
    $display("test modes done");
  endtask
  task automatic testTone();
    int nf;
    int nh;
    nf = 0;
    nh = 0;
    @(posedge core_clk);
    baseDevice <= 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h6);
    waitTone(1'b0, HB_PERIOD_CYC + 100);
    @(posedge core_clk);
    faultIn[0] <= 1'b1;
    waitTone(1'b1, 20);
    // one retry period plus margin must hold exactly one more fault tone
    for (int k = 0; k < TONE_RETRY_CYC + 100; k++)
    begin
      tick(1);
      nf += faultTone;
      nh += heartbeatTone;
    end
    chk(nf, 1, "fault retry count");
    chk(nh, 0, "heartbeat stopped");
    setF(0, 1'b0);
    apb(1'b1, adr(RST_BASE, IDX_PIN_INPUT), 32'h1);
    waitTone(1'b0, HB_PERIOD_CYC + 100);
    $display("test tone done");
  endtask

  // *************
  // clock and run
  // *************
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hang guard: a stuck run is reported as a mismatch
  initial
  begin
    repeat (100000) @(posedge core_clk);
    $display("[FAIL] %0t watchdog expired", $time);
    nMismatch++;
    conclude();
  end
  initial
  begin
    nMismatch = 0;
    compares = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    faultIn = '0;
    pwrMode = PWR_ACTIVE;
    baseDevice = 1'b1;
    multidrop = 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    testReset();
    testLatch();
    testMask();
    testGroups();
    testModes();
    testTone();
    conclude();
  end
endmodule
